// ==== ccs_clock_ctrl.sv ====
/*
 CPU clock switchover controller: control register, oscillator stabilization,
 instruction-rate tick generation and delayed clock switchover.
 Assumes the host obeys the software-side ordering on the link.
*/
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
// Summary of operation
// R1: Divide field and source bit select CPU clock
// R2: Old clock runs on for bounded instructions
// R3: Readable status shows active clock source
// R4: Divide change delay 16/8/4/2/1, subsystem 1
// R5: Main-to-sub delay 64 scaled by old divide
// R6: Delay counted in old clock instruction times
// R7: Software never changes divide with main-to-sub
// R8: Sub-to-main with divide change applies both
// R9: Reset waits 2^17 main periods before running
// R10: After reset run slowest main divide
// R11: Clearing stop bit restarts main oscillator
// R12: Software selects subclock only when stable
// R13: Software waits stabilization after main restart
// R14: Reset loads control value 04h
// R15: Stop bit halts main only on subclock
// R16: Subclock instruction time ignores divide field
// R17: Status bit changes at actual switchover
`timescale 1ns/10ps
module ccs_clock_ctrl
	import ccs_pkg::*;
#(
	parameter int MAIN_DIVIDE  = MAIN_DIV,
	parameter int SUB_DIVIDE   = SUB_DIV,
	parameter int STAB_COUNT   = STAB_PERIODS
) (
	input  wire logic clk,
	input  wire logic srst,
	ccs_if.dev        link
);
	initial begin
		if (MAIN_DIVIDE < 1 || MAIN_DIVIDE > 65535 || SUB_DIVIDE < 1 || SUB_DIVIDE > 65535)
			$error("Prescaler divide out of range");
		if (STAB_COUNT < 1 || STAB_COUNT > 262143)
			$error("Stabilization count out of range");
	end

	localparam logic [15:0] MAIN_LAST = 16'(MAIN_DIVIDE - 1);
	localparam logic [15:0] SUB_LAST  = 16'(SUB_DIVIDE - 1);
	localparam logic [17:0] STAB_LAST = 18'(STAB_COUNT - 1);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [15:0] mpre_q,  mpre_d;
	logic [15:0] spre_q,  spre_d;
	logic [17:0] stab_q,  stab_d;
	logic        run_q,   run_d;
	logic [5:0]  icnt_q,  icnt_d;
	logic [2:0]  div_q,   div_d;
	logic        cls_q,   cls_d;
	logic [2:0]  divreg_q, divreg_d;
	logic        css_q,   css_d;
	logic        mcc_q,   mcc_d;
	logic        frc_q,   frc_d;
	logic        pend_q,  pend_d;
	logic [7:0]  pcnt_q,  pcnt_d;
	logic        osc_q,   osc_d;
	logic        tick_q,  tick_d;
	logic [7:0]  rdata_q, rdata_d;

	logic        mtick;
	logic        stick;
	logic        itick;
	logic [5:0]  ilast;
	logic [2:0]  wdiv;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		mtick = osc_q && (mpre_q == MAIN_LAST);
		stick = (spre_q == SUB_LAST);
		ilast = cls_q ? SUB_INSTR_LAST : 6'((6'h02 << div_q) - 6'h01); // R16
		itick = run_q && (cls_q ? stick : mtick) && (icnt_q == ilast); // R6
		wdiv  = (link.pcc_wdata[DIV_LSB +: DIV_W] > DIV_SLOWEST) ? DIV_SLOWEST :
			link.pcc_wdata[DIV_LSB +: DIV_W];

		mpre_d   = mpre_q;
		spre_d   = (spre_q == SUB_LAST) ? 16'h0000 : spre_q + 16'h0001;
		stab_d   = stab_q;
		run_d    = run_q;
		icnt_d   = icnt_q;
		div_d    = div_q;
		cls_d    = cls_q;
		divreg_d = divreg_q;
		css_d    = css_q;
		mcc_d    = mcc_q;
		frc_d    = frc_q;
		pend_d   = pend_q;
		pcnt_d   = pcnt_q;
		tick_d   = itick;

		if (osc_q)
			mpre_d = (mpre_q == MAIN_LAST) ? 16'h0000 : mpre_q + 16'h0001;
		else
			mpre_d = 16'h0000;

		if (!run_q && mtick) begin
			if (stab_q == STAB_LAST)
				run_d = 1'b1; // R9
			else
				stab_d = stab_q + 18'h00001;
		end

		if (run_q && (cls_q ? stick : mtick))
			icnt_d = (icnt_q == ilast) ? 6'h00 : icnt_q + 6'h01;

		if (pend_q && itick) begin
			if (pcnt_q <= 8'h01) begin
				div_d  = divreg_q; // R8
				cls_d  = css_q; // R17
				pend_d = 1'b0;
				icnt_d = 6'h00;
			end else begin
				pcnt_d = pcnt_q - 8'h01; // R2
			end
		end

		if (link.pcc_wr) begin
			divreg_d = wdiv; // R1
			css_d    = link.pcc_wdata[CSS_BIT];
			mcc_d    = link.pcc_wdata[MCC_BIT];
			frc_d    = link.pcc_wdata[FRC_BIT];
			pend_d   = 1'b1;
			if (cls_q)
				pcnt_d = SW_FROM_SUB; // R4
			else if (link.pcc_wdata[CSS_BIT])
				pcnt_d = ((SW_SUB_BASE >> div_q) == 8'h00) ? 8'h01 : (SW_SUB_BASE >> div_q); // R5
			else
				pcnt_d = SW_MAIN_BASE >> div_q; // R4
		end

		osc_d   = !(mcc_d && cls_d); // R11 R15
		rdata_d = {mcc_d, frc_d, cls_d, css_d, 1'b0, divreg_d}; // R3
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			mpre_q   <= 16'h0000;
			spre_q   <= 16'h0000;
			stab_q   <= 18'h00000;
			run_q    <= 1'b0;
			icnt_q   <= 6'h00;
			div_q    <= PCC_RESET[DIV_LSB +: DIV_W]; // R10 R14
			cls_q    <= 1'b0;
			divreg_q <= PCC_RESET[DIV_LSB +: DIV_W];
			css_q    <= PCC_RESET[CSS_BIT];
			mcc_q    <= PCC_RESET[MCC_BIT];
			frc_q    <= PCC_RESET[FRC_BIT];
			pend_q   <= 1'b0;
			pcnt_q   <= 8'h00;
			osc_q    <= 1'b1;
			tick_q   <= 1'b0;
			rdata_q  <= PCC_RESET;
		end else begin
			mpre_q   <= mpre_d;
			spre_q   <= spre_d;
			stab_q   <= stab_d;
			run_q    <= run_d;
			icnt_q   <= icnt_d;
			div_q    <= div_d;
			cls_q    <= cls_d;
			divreg_q <= divreg_d;
			css_q    <= css_d;
			mcc_q    <= mcc_d;
			frc_q    <= frc_d;
			pend_q   <= pend_d;
			pcnt_q   <= pcnt_d;
			osc_q    <= osc_d;
			tick_q   <= tick_d;
			rdata_q  <= rdata_d;
		end
	end

	assign link.pcc_rdata   = rdata_q;
	assign link.cpu_tick    = tick_q;
	assign link.cpu_run     = run_q;
	assign link.main_osc_on = osc_q;
	assign link.sw_pending  = pend_q;
endmodule

// ==== ccs_pkg.sv ====
/*
 Constants shared by both ends of the CPU clock switchover link: control
 register layout, reset value, switchover counts, rates and host offsets.
 Assumes a single 100 MHz system clock on which both ends run.
*/
package ccs_pkg;
	// ----------------------------------------------------------------
	// Processor clock control layout
	// ----------------------------------------------------------------
	localparam logic [7:0]  PCC_RESET       = 8'h04;
	localparam int          DIV_LSB         = 0;
	localparam int          DIV_W           = 3;
	localparam int          CSS_BIT         = 4;
	localparam int          CLS_BIT         = 5;
	localparam int          FRC_BIT         = 6;
	localparam int          MCC_BIT         = 7;
	localparam logic [2:0]  DIV_SLOWEST     = 3'h4;

	// ----------------------------------------------------------------
	// Switchover counts in old-clock instructions
	// ----------------------------------------------------------------
	localparam logic [7:0]  SW_MAIN_BASE    = 8'h10;
	localparam logic [7:0]  SW_SUB_BASE     = 8'h40;
	localparam logic [7:0]  SW_FROM_SUB     = 8'h01;

	// ----------------------------------------------------------------
	// Rates
	// ----------------------------------------------------------------
	localparam int          CLK_FREQ_HZ     = 100000000;
	localparam int          MAIN_FREQ_HZ    = 5000000;
	localparam int          SUB_FREQ_HZ     = 32768;
	localparam int          MAIN_DIV        = CLK_FREQ_HZ / MAIN_FREQ_HZ;
	localparam int          SUB_DIV         = CLK_FREQ_HZ / SUB_FREQ_HZ;
	localparam int          STAB_EXP        = 17;
	localparam int          STAB_PERIODS    = 2 ** STAB_EXP;
	localparam logic [5:0]  SUB_INSTR_LAST  = 6'h03;
	localparam int          HOST_STAB_CYCLES = STAB_PERIODS * MAIN_DIV;

	// ----------------------------------------------------------------
	// Host register map (byte offsets) and status bits
	// ----------------------------------------------------------------
	localparam logic [3:0]  CTRL_OFS        = 4'h0;
	localparam logic [3:0]  STATUS_OFS      = 4'h4;
	localparam logic [3:0]  ICOUNT_OFS      = 4'h8;
	localparam int          ST_CLS          = 0;
	localparam int          ST_RUN          = 1;
	localparam int          ST_OSC          = 2;
	localparam int          ST_PEND         = 3;
	localparam int          ST_REFUSED      = 4;
	localparam int          ST_WAIT         = 5;
endpackage

// ==== ccs_if.sv ====
/*
 Link between the clock switchover controller and its host.
 Assumes both ends share clk; no crossing is needed on this link.
*/
`timescale 1ns/10ps
interface ccs_if;
	logic       pcc_wr;
	logic [7:0] pcc_wdata;
	logic [7:0] pcc_rdata;
	logic       cpu_tick;
	logic       cpu_run;
	logic       main_osc_on;
	logic       sw_pending;

	modport dev (
		input  pcc_wr,
		input  pcc_wdata,
		output pcc_rdata,
		output cpu_tick,
		output cpu_run,
		output main_osc_on,
		output sw_pending
	);
	modport ctl (
		output pcc_wr,
		output pcc_wdata,
		input  pcc_rdata,
		input  cpu_tick,
		input  cpu_run,
		input  main_osc_on,
		input  sw_pending
	);
endinterface

// ==== ccs_host.sv ====
/*
 Host end: Avalon-MM slave that software uses to order clock changes, with
 the divide hold and stable check on selecting the subclock and the wait after clearing the stop bit enforced before values go to the controller.
 Assumes sub_clock_stable is an asynchronous level from outside.
*/
`timescale 1ns/10ps
module ccs_host
	import ccs_pkg::*;
#(
	parameter int STAB_WAIT_CYCLES = HOST_STAB_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        srst,
	ccs_if.ctl               link,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        sub_clock_stable,
	output logic             cpu_step,
	output logic             cpu_running
);
	initial begin
		if (STAB_WAIT_CYCLES < 1 || STAB_WAIT_CYCLES > 16777215)
			$error("Stabilization wait out of range");
	end

	localparam logic [23:0] WAIT_LAST = 24'(STAB_WAIT_CYCLES);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic        s1_q, s2_q;
	logic        wait_q,  wait_d;
	logic [31:0] rd_q,    rd_d;
	logic [7:0]  shadow_q, shadow_d;
	logic        wr_q,    wr_d;
	logic [7:0]  wdat_q,  wdat_d;
	logic        refused_q, refused_d;
	logic [23:0] swait_q, swait_d;
	logic [31:0] icount_q, icount_d;
	logic        step_q,  run_q;

	logic        req;
	logic        done;
	logic [7:0]  fwd;
	logic        refuse;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		req    = avs_read || avs_write;
		done   = req && !wait_q;
		fwd    = avs_writedata[7:0];
		refuse = 1'b0;
		fwd[CLS_BIT] = 1'b0;
		if (fwd[DIV_LSB +: DIV_W] > DIV_SLOWEST)
			fwd[DIV_LSB +: DIV_W] = DIV_SLOWEST;
		if (!shadow_q[CSS_BIT] && fwd[CSS_BIT]) begin
			fwd[DIV_LSB +: DIV_W] = shadow_q[DIV_LSB +: DIV_W]; // R7
			if (!s2_q) begin
				fwd[CSS_BIT] = 1'b0; // R12
				refuse       = 1'b1;
			end
		end
		if (shadow_q[CSS_BIT] && !fwd[CSS_BIT] &&
			((shadow_q[MCC_BIT] && !fwd[MCC_BIT]) || swait_q != 24'h000000)) begin
			fwd[CSS_BIT] = 1'b1; // R13
			refuse       = 1'b1;
		end

		wait_d    = !(req && wait_q);
		rd_d      = rd_q;
		shadow_d  = shadow_q;
		wr_d      = 1'b0;
		wdat_d    = wdat_q;
		refused_d = refused_q;
		swait_d   = (swait_q != 24'h000000) ? swait_q - 24'h000001 : swait_q;
		icount_d  = link.cpu_tick ? icount_q + 32'h00000001 : icount_q;

		if (req && wait_q) begin
			unique case (avs_address)
				CTRL_OFS:   rd_d = {24'h000000, shadow_q[7:6], link.pcc_rdata[CLS_BIT], shadow_q[4:0]};
				STATUS_OFS: rd_d = {26'h0000000, swait_q != 24'h000000, refused_q, link.sw_pending,
					link.main_osc_on, link.cpu_run, link.pcc_rdata[CLS_BIT]};
				ICOUNT_OFS: rd_d = icount_q;
				default:    rd_d = 32'h00000000;
			endcase
		end

		if (done && avs_write && avs_address == STATUS_OFS && avs_byteenable[0] &&
			avs_writedata[ST_REFUSED])
			refused_d = 1'b0;
		if (done && avs_write && avs_address == CTRL_OFS && avs_byteenable[0]) begin
			wr_d     = 1'b1;
			wdat_d   = fwd;
			shadow_d = fwd;
			if (shadow_q[MCC_BIT] && !fwd[MCC_BIT])
				swait_d = WAIT_LAST; // R13
			if (refuse)
				refused_d = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_q      <= 1'b0;
			s2_q      <= 1'b0;
			wait_q    <= 1'b1;
			rd_q      <= 32'h00000000;
			shadow_q  <= PCC_RESET;
			wr_q      <= 1'b0;
			wdat_q    <= PCC_RESET;
			refused_q <= 1'b0;
			swait_q   <= 24'h000000;
			icount_q  <= 32'h00000000;
			step_q    <= 1'b0;
			run_q     <= 1'b0;
		end else begin
			s1_q      <= sub_clock_stable;
			s2_q      <= s1_q;
			wait_q    <= wait_d;
			rd_q      <= rd_d;
			shadow_q  <= shadow_d;
			wr_q      <= wr_d;
			wdat_q    <= wdat_d;
			refused_q <= refused_d;
			swait_q   <= swait_d;
			icount_q  <= icount_d;
			step_q    <= link.cpu_tick;
			run_q     <= link.cpu_run;
		end
	end

	assign link.pcc_wr    = wr_q;
	assign link.pcc_wdata = wdat_q;
	assign avs_readdata    = rd_q;
	assign avs_waitrequest = wait_q;
	assign cpu_step        = step_q;
	assign cpu_running     = run_q;
endmodule

// ==== ccs_sva.sv ====
/*
 Checker for the switchover link: tick timing, switchover counts, status moments.
 Assumes it sits beside the link, given the device's parameters.
*/
`timescale 1ns/10ps
module ccs_sva
	import ccs_pkg::*;
#(
	parameter int MAIN_DIVIDE = MAIN_DIV,
	parameter int SUB_DIVIDE  = SUB_DIV,
	parameter int STAB_COUNT  = STAB_PERIODS
) (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       pcc_wr,
	input wire logic [7:0] pcc_wdata,
	input wire logic [7:0] pcc_rdata,
	input wire logic       cpu_tick,
	input wire logic       cpu_run,
	input wire logic       main_osc_on,
	input wire logic       sw_pending
);
	localparam int RUN_LO = STAB_COUNT * MAIN_DIVIDE - 3;
	localparam int RUN_HI = STAB_COUNT * MAIN_DIVIDE + 3;
	logic [7:0]  exp_q, exp_d, cnt_q, cnt_d;
	logic [15:0] gap_q, gap_d;
	logic [4:0]  ref_q, ref_d;
	logic [31:0] run_q, run_d;
	logic        pdly_q, wdly_q;

	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	always_comb begin
		exp_d = exp_q;
		cnt_d = cnt_q;
		if (pcc_wr) begin
			cnt_d = 8'h00;
			exp_d = pcc_rdata[5] ? SW_FROM_SUB : ((pcc_wdata[4] ? SW_SUB_BASE : SW_MAIN_BASE) >> pcc_rdata[2:0]);
		end else if (cpu_tick && pdly_q && !wdly_q) begin
			// Tick seen one cycle after the instruction the device counted
			cnt_d = cnt_q + 8'h01;
		end
		gap_d = cpu_tick ? 16'h0000 : gap_q + 16'h0001;
		// Switchover tick restarts the phase, so it is no reference
		ref_d = cpu_tick ? {~sw_pending & ~pdly_q, pcc_rdata[5], pcc_rdata[2:0]} : ref_q;
		run_d = cpu_run ? run_q : run_q + 32'h1;
	end
	always_ff @(posedge clk) begin
		exp_q <= srst ? 8'h00 : exp_d;
		cnt_q <= srst ? 8'h00 : cnt_d;
		gap_q <= srst ? 16'h0000 : gap_d;
		ref_q <= srst ? 5'h00 : ref_d;
		run_q <= srst ? 32'h0 : run_d;
		pdly_q <= srst ? 1'b0 : sw_pending;
		wdly_q <= srst ? 1'b0 : pcc_wr;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	chk_tick_gated: assert property (!cpu_run |-> !cpu_tick)
		else $error("tick before stabilization");
	chk_run_delay: assert property ($rose(cpu_run) |-> 32'(RUN_LO) <= run_q && run_q <= 32'(RUN_HI)
		&& pcc_rdata[5] == 1'b0 && pcc_rdata[2:0] == DIV_SLOWEST)
		else $error("stabilization time or start mode wrong");
	chk_write_takes: assert property (pcc_wr |=> sw_pending && pcc_rdata[7] == $past(pcc_wdata[7])
		&& pcc_rdata[4] == $past(pcc_wdata[4])
		&& pcc_rdata[2:0] == (($past(pcc_wdata[2:0]) > 3'h4) ? 3'h4 : $past(pcc_wdata[2:0])))
		else $error("control write not taken");
	chk_cls_moment: assert property ($changed(pcc_rdata[5]) |-> $past(sw_pending) && cpu_tick)
		else $error("source status moved off a switchover tick");
	chk_switch_count: assert property ($fell(sw_pending) |-> cpu_tick && cnt_q + 8'h01 == exp_q)
		else $error("switchover instruction count wrong");
	chk_main_period: assert property (cpu_tick && ref_q[4] && !ref_q[3] && !sw_pending && !pcc_rdata[5]
		&& ref_q[2:0] == pcc_rdata[2:0] |-> 32'(gap_q) == MAIN_DIVIDE * (2 << pcc_rdata[2:0]) - 1)
		else $error("main instruction time wrong");
	chk_sub_period: assert property (cpu_tick && ref_q[4] && ref_q[3] && !sw_pending && pcc_rdata[5]
		|-> 32'(gap_q) == 4 * SUB_DIVIDE - 1)
		else $error("subclock instruction time wrong");
	chk_osc_follow: assert property (main_osc_on == !(pcc_rdata[7] && pcc_rdata[5]))
		else $error("main oscillator state wrong");
	cover property ($rose(pcc_rdata[5]));
	cover property ($fell(pcc_rdata[5]));
	cover property ($fell(main_osc_on));
endmodule

// ==== ccs_bench.sv ====
/*
 Self-checking bench: host and controller joined by the link, driven over Avalon-MM.
 Assumes shortened stabilization counts and clock dividers.
*/
`timescale 1ns/10ps
module ccs_bench
	import ccs_pkg::*;
;
	logic        clk, srst, rd, wr, stab, wt, step, running;
	logic [3:0]  adr, be, bsel;
	logic [31:0] wd, rdat, q;
	int          fail_count, check_count, steps;
	localparam int TB_MAIN = 4;
	localparam int TB_SUB  = 16;
	localparam int TB_STAB = 16;
	ccs_if lnk();
	ccs_clock_ctrl #(.MAIN_DIVIDE(TB_MAIN), .SUB_DIVIDE(TB_SUB), .STAB_COUNT(TB_STAB)) i_ccs_clock_ctrl (.clk(clk),
		.srst(srst), .link(lnk));
	ccs_host #(.STAB_WAIT_CYCLES(64)) i_ccs_host (.clk(clk), .srst(srst), .link(lnk), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wt), .sub_clock_stable(stab), .cpu_step(step), .cpu_running(running));
	ccs_sva #(.MAIN_DIVIDE(TB_MAIN), .SUB_DIVIDE(TB_SUB), .STAB_COUNT(TB_STAB)) i_ccs_sva (.clk(clk), .srst(srst),
		.pcc_wr(lnk.pcc_wr), .pcc_wdata(lnk.pcc_wdata), .pcc_rdata(lnk.pcc_rdata), .cpu_tick(lnk.cpu_tick),
		.cpu_run(lnk.cpu_run), .main_osc_on(lnk.main_osc_on), .sw_pending(lnk.sw_pending));

	// Instruction steps seen on the host output
	always @(posedge clk) begin
		if (srst) steps <= 0;
		else if (step === 1'b1) steps <= steps + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a; wr <= w; rd <= !w; wd <= d; be <= bsel;
		@(posedge clk);
		while (wt !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) fail_count++;
		q = rdat;
		rd <= 1'b0; wr <= 1'b0;
	endtask
	task automatic idle();
		int n;
		n = 0;
		repeat (3) @(posedge clk);
		while (lnk.sw_pending !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) fail_count++;
		repeat (2) @(posedge clk);
	endtask
	task automatic w8(input logic [7:0] d);
		bus(1'b1, CTRL_OFS, {24'h0, d});
		idle();
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		int n;
		bus(1'b0, CTRL_OFS, 0);
		chk(q[7:0], PCC_RESET);
		bus(1'b0, STATUS_OFS, 0);
		chk(q[2:0], 3'b100);
		for (n = 0; n < 500 && running !== 1'b1; n++) @(posedge clk);
		if (running !== 1'b1) fail_count++;
		bus(1'b0, STATUS_OFS, 0);
		chk(q[1], 1'b1);
		$display("reset test done");
	endtask
	task automatic t_div();
		logic [2:0] tv[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
		for (int i = 0; i < 6; i++) begin
			w8({5'h0, tv[i]});
			chk(lnk.pcc_rdata, {5'h0, (tv[i] > 3'h4) ? 3'h4 : tv[i]});
		end
		bsel = 4'he;
		bus(1'b1, CTRL_OFS, 32'h0);
		bsel = 4'hf;
		repeat (4) @(posedge clk);
		chk(lnk.sw_pending, 1'b0);
		chk(lnk.pcc_rdata, 8'h04);
		$display("divide test done");
	endtask
	task automatic t_sub();
		w8(8'h90);
		chk(lnk.pcc_rdata, 8'h84);
		chk(lnk.main_osc_on, 1'b1);
		bus(1'b0, STATUS_OFS, 0);
		chk(q[4], 1'b1);
		bus(1'b1, STATUS_OFS, 32'h10);
		stab <= 1'b1;
		repeat (4) @(posedge clk);
		w8(8'h91);
		chk(lnk.pcc_rdata, 8'hb4);
		chk(lnk.main_osc_on, 1'b0);
		bus(1'b0, STATUS_OFS, 0);
		chk(q[0], 1'b1);
		$display("subclock test done");
	endtask
	task automatic t_back();
		w8(8'h93);
		chk(lnk.pcc_rdata, 8'hb3);
		repeat (200) @(posedge clk);
		bus(1'b1, CTRL_OFS, 32'h13);
		bus(1'b1, CTRL_OFS, 32'h00);
		bus(1'b0, STATUS_OFS, 0);
		chk(q[5], 1'b1);
		chk(q[4], 1'b1);
		idle();
		chk(lnk.main_osc_on, 1'b1);
		chk(lnk.pcc_rdata[5], 1'b1);
		repeat (80) @(posedge clk);
		w8(8'h00);
		bus(1'b0, CTRL_OFS, 0);
		chk(q[7:0], 8'h00);
		bus(1'b0, 4'hc, 0);
		chk(q, 32'h0);
		bus(1'b0, ICOUNT_OFS, 0);
		chk(q, steps);
		chk(steps != 0, 1'b1);
		$display("return test done");
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300000;
		fail_count++;
		finish_test();
	end
	initial begin
		srst = 1'b1; rd = 1'b0; wr = 1'b0; adr = 4'h0; wd = 32'h0; be = 4'h0; stab = 1'b0;
		bsel = 4'hf;
		fail_count = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_div();
		t_sub();
		t_back();
		finish_test();
	end
endmodule
